// ### logic/ssport_top.sv
`timescale 1ns/100ps
module ssport_top (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // timer two output pulse, same clock
   input  wire logic        timer_two_tick,
   // serial pins
   input  wire logic        sclk_i,
   output logic             sclk_o,
   output logic             sclk_oe_n,
   input  wire logic        data_in_i,
   output logic             data_out_o,
   output logic             data_out_oe_n,
   input  wire logic        slave_sel_n_i,
   // pin ownership and event flag
   output logic             port_pins_sel,
   output logic             ss_pin_sel,
   output logic             port_interrupt_flag
);
   // ****************************************
   // state
   // ****************************************
   logic                     write_collision_flag_q, ovf_q, en_q, ckp_q, smp_q, cke_q, full_q;
   logic [3:0]               mode_q;
   logic [2:0]               dir_q, s1_q, s2_q, s3_q, pin_q, bit_cnt_q;
   logic [7:0]               buf_q, sr_q, wr_addr_q, rd_byte;
   logic [4:0]               edge_q, pulse_cnt_q;
   logic [5:0]               div_q;
   logic                     sclk_prev_q, wr_pend_q;
   ssport_pkg::ssport_mst_t  mst_q;
   logic                     acc, buf_rd, buf_wr, wr_ctrl, wr_stat, wr_dir;
   logic                     spi_ok, master, slave, ss_ctl, ss_off, port_rst;
   logic                     m_run, tick, m_lead, m_trail, m_end, s_chg, s_lead, s_trail;
   logic                     lead, trail, chg, samp, done, busy, load, ovf_set, coll;
   logic [7:0]               sr_next, rx_q, rx_next;
   logic [3:0]               cap_dly_q;
   logic                     cap;

   function automatic logic [5:0] half_m1(input logic [3:0] mode);
      if (mode == ssport_pkg::MODE_M4)
         return ssport_pkg::HALF4_M1;
      else if (mode == ssport_pkg::MODE_M16)
         return ssport_pkg::HALF16_M1;
      else
         return ssport_pkg::HALF64_M1;
   endfunction : half_m1

   // ****************************************
   // bus slave
   // ****************************************
   assign acc     = hsel & hready & htrans[ssport_pkg::HTRANS_ACT];
   assign buf_rd  = acc & ~hwrite & (haddr[7:0] == ssport_pkg::ADDR_BUF);
   assign buf_wr  = wr_pend_q & (wr_addr_q == ssport_pkg::ADDR_BUF);
   assign wr_ctrl = wr_pend_q & (wr_addr_q == ssport_pkg::ADDR_CTRL);
   assign wr_stat = wr_pend_q & (wr_addr_q == ssport_pkg::ADDR_STAT);
   assign wr_dir  = wr_pend_q & (wr_addr_q == ssport_pkg::ADDR_DIR);

   always_comb
   begin
      rd_byte = ssport_pkg::BYTE_RST;
      if (haddr[7:0] == ssport_pkg::ADDR_CTRL)
         rd_byte = {write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q};
      else if (haddr[7:0] == ssport_pkg::ADDR_BUF)
         rd_byte = buf_q;
      else if (haddr[7:0] == ssport_pkg::ADDR_STAT)
         rd_byte = {smp_q, cke_q, 4'h0, port_interrupt_flag, full_q};
      else if (haddr[7:0] == ssport_pkg::ADDR_DIR)
         rd_byte = {5'h00, dir_q[2:1], dir_q[ssport_pkg::DIR_DOUT] | ss_off};
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= ssport_pkg::BYTE_RST;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= ssport_pkg::HRESP_OKAY;
      end
      else
      begin
         if (hready)
         begin
            wr_pend_q <= acc & hwrite;
            wr_addr_q <= haddr[7:0];
         end
         if (acc & ~hwrite)
            hrdata <= {24'h00_0000, rd_byte};
         hreadyout <= 1'b1;
         hresp     <= ssport_pkg::HRESP_OKAY;
      end
   end

   // ****************************************
   // control and direction registers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         en_q   <= 1'b0;
         ckp_q  <= 1'b0;
         mode_q <= ssport_pkg::MODE_RST;
         smp_q  <= 1'b0;
         cke_q  <= 1'b0;
         dir_q  <= ssport_pkg::DIR_RST;
      end
      else
      begin
         if (wr_ctrl)
         begin
            en_q   <= hwdata[5];
            ckp_q  <= hwdata[4];
            mode_q <= hwdata[3:0];
         end
         if (wr_stat)
         begin
            smp_q <= hwdata[7];
            cke_q <= hwdata[6];
         end
         if (wr_dir)
            dir_q <= hwdata[2:0];
      end
   end

   // set beats a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         write_collision_flag_q              <= 1'b0;
         ovf_q               <= 1'b0;
         port_interrupt_flag <= 1'b0;
         full_q              <= 1'b0;
      end
      else
      begin
         write_collision_flag_q              <= coll | (wr_ctrl ? hwdata[7] : write_collision_flag_q);
         ovf_q               <= ovf_set | (wr_ctrl ? hwdata[6] : ovf_q);
         port_interrupt_flag <= load | (wr_stat ? hwdata[1] : port_interrupt_flag);
         full_q              <= load | (full_q & ~buf_rd);
      end
   end

   // ****************************************
   // pin synchronisers {select, data in, clock}
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s1_q        <= ssport_pkg::PIN_RST;
         s2_q        <= ssport_pkg::PIN_RST;
         s3_q        <= ssport_pkg::PIN_RST;
         pin_q       <= ssport_pkg::PIN_RST;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         s1_q        <= {slave_sel_n_i, data_in_i, sclk_i};
         s2_q        <= s1_q;
         s3_q        <= s2_q;
         pin_q       <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
         sclk_prev_q <= pin_q[ssport_pkg::PIN_SCLK];
      end
   end

   // ****************************************
   // mode decode and edge selection
   // ****************************************
   assign spi_ok   = en_q & (mode_q <= ssport_pkg::MODE_SNS);
   assign master   = spi_ok & (mode_q <= ssport_pkg::MODE_MT2);
   assign slave    = spi_ok & ~master;
   assign ss_ctl   = spi_ok & (mode_q == ssport_pkg::MODE_SSS);
   assign ss_off   = ss_ctl & pin_q[ssport_pkg::PIN_SSEL];
   assign port_rst = ~spi_ok | ss_off;
   assign m_run    = (mst_q == ssport_pkg::MST_SHIFT);
   assign tick     = (mode_q == ssport_pkg::MODE_MT2) ? timer_two_tick : (div_q == half_m1(mode_q));
   assign m_lead   = m_run & tick & ~edge_q[0] & (edge_q != ssport_pkg::EDGE_END);
   assign m_trail  = m_run & tick & edge_q[0];
   assign m_end    = m_run & tick & (edge_q == ssport_pkg::EDGE_END);
   assign s_chg    = slave & ~ss_off & (pin_q[ssport_pkg::PIN_SCLK] ^ sclk_prev_q);
   assign s_lead   = s_chg & (pin_q[ssport_pkg::PIN_SCLK] != ckp_q);
   assign s_trail  = s_chg & (pin_q[ssport_pkg::PIN_SCLK] == ckp_q);
   assign lead     = m_lead | s_lead;
   assign trail    = m_trail | s_trail;
   assign chg      = cke_q ? trail : lead;
   // sample phase only matters to a master; a slave always samples mid-bit
   assign samp     = (master & smp_q) ? (cke_q ? m_trail : ((m_lead & (edge_q != 5'h00)) | m_end))
                                      : (cke_q ? lead : trail);
   // returning master data crosses the pin synchroniser, so capture trails the edge
   assign cap      = master ? cap_dly_q[3] : samp;
   assign done     = cap & (bit_cnt_q == ssport_pkg::BIT_LAST);
   assign sr_next  = {sr_q[6:0], pin_q[ssport_pkg::PIN_DIN]};
   assign rx_next  = {rx_q[6:0], pin_q[ssport_pkg::PIN_DIN]};
   assign busy     = m_run | (bit_cnt_q != 3'h0) | (cap_dly_q != 4'h0);
   assign coll     = buf_wr & busy;
   assign ovf_set  = done & slave & full_q;
   assign load     = done & ~(slave & full_q);

   // ****************************************
   // shift register and receive buffer
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sr_q       <= ssport_pkg::BYTE_RST;
         data_out_o <= 1'b0;
         buf_q      <= ssport_pkg::BYTE_RST;
         rx_q       <= ssport_pkg::BYTE_RST;
      end
      else
      begin
         if (buf_wr & ~busy)
         begin
            sr_q       <= hwdata[7:0];
            data_out_o <= hwdata[7];
         end
         else
         begin
            if (samp)
               sr_q <= sr_next;
            if (chg)
               data_out_o <= samp ? sr_q[6] : sr_q[7];
         end
         if (cap)
            rx_q <= rx_next;
         if (load)
            buf_q <= rx_next;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         bit_cnt_q <= 3'h0;
      else if (port_rst)
         bit_cnt_q <= 3'h0;
      else if (cap)
         bit_cnt_q <= bit_cnt_q + 3'h1;
   end

   // four cycles covers the round trip through the four pin flops at any rate
   always_ff @(posedge clk)
   begin
      if (sys_rst | port_rst)
         cap_dly_q <= 4'h0;
      else
         cap_dly_q <= {cap_dly_q[2:0], samp & master};
   end

   // ****************************************
   // master clock generator
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mst_q  <= ssport_pkg::MST_IDLE;
         edge_q <= 5'h00;
         div_q  <= 6'h00;
      end
      else
      begin
         div_q <= (~m_run | tick) ? 6'h00 : div_q + 6'h01;
         case (mst_q)
            ssport_pkg::MST_IDLE:
            begin
               edge_q <= 5'h00;
               if (buf_wr & ~busy & master & ~port_rst)
                  mst_q <= ssport_pkg::MST_SHIFT;
            end
            ssport_pkg::MST_SHIFT:
            begin
               if (port_rst | m_end)
                  mst_q <= ssport_pkg::MST_IDLE;
               else if (tick)
                  edge_q <= edge_q + 5'h01;
            end
            default:
               mst_q <= ssport_pkg::MST_IDLE;
         endcase
      end
   end

   // ****************************************
   // pin drivers
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sclk_o        <= 1'b0;
         sclk_oe_n     <= 1'b1;
         data_out_oe_n <= 1'b1;
         port_pins_sel <= 1'b0;
         ss_pin_sel    <= 1'b0;
      end
      else
      begin
         if (~m_run | port_rst)
            sclk_o <= ckp_q;
         else if (m_lead | m_trail)
            sclk_o <= ~sclk_o;
         sclk_oe_n     <= ~(master & ~dir_q[ssport_pkg::DIR_SCLK]);
         data_out_oe_n <= ~(spi_ok & ~dir_q[ssport_pkg::DIR_DOUT] & ~ss_off);
         port_pins_sel <= spi_ok;
         ss_pin_sel    <= ss_ctl;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   always_ff @(posedge clk)
   begin
      if (sys_rst | ~m_run)
         pulse_cnt_q <= 5'h00;
      else if (m_lead | m_trail)
         pulse_cnt_q <= pulse_cnt_q + 5'h01;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   write_collision_flag_set_a: assert property (
      coll |=> write_collision_flag_q && sr_q == ($past(samp) ? $past(sr_next) : $past(sr_q)))
      else $error("collision not flagged");
   ovf_slave_a: assert property (
      ovf_set && !buf_rd |=> ovf_q && full_q && buf_q == $past(buf_q))
      else $error("slave overflow wrong");
   ovf_master_a: assert property (
      $rose(ovf_q) && !$past(wr_ctrl) |-> $past(slave))
      else $error("overflow set outside slave");
   ovf_hold_a: assert property (
      ovf_q && !wr_ctrl |=> ovf_q)
      else $error("overflow cleared by itself");
   pins_off_a: assert property (
      !en_q |=> !port_pins_sel && data_out_oe_n && sclk_oe_n)
      else $error("pins held while disabled");
   pulse_count_a: assert property (
      m_end |-> pulse_cnt_q == 5'h10 ##1 sclk_o == $past(ckp_q))
      else $error("not eight clock pulses");
   ss_reset_a: assert property (
      ss_off |=> bit_cnt_q == 3'h0 && data_out_oe_n)
      else $error("select high did not reset");
   load_flags_a: assert property (
      load |=> full_q && port_interrupt_flag && buf_q == $past(rx_next))
      else $error("byte not loaded");
   full_clear_a: assert property (
      buf_rd && !load |=> !full_q)
      else $error("read did not clear full");
   i2c_idle_a: assert property (
      en_q && mode_q > ssport_pkg::MODE_SNS |=> !port_pins_sel && !m_run)
      else $error("port active in other mode");
   dir_read_a: assert property (
      ss_off && acc && !hwrite && haddr[7:0] == ssport_pkg::ADDR_DIR |=> hrdata[0])
      else $error("direction readback wrong");

   master_done_c: cover property (master && load);
   slave_ovf_c: cover property (ovf_set);
   collision_c: cover property (coll);
endmodule : ssport_top

// ### logic/ssport_pkg.sv
package ssport_pkg;
   // ****************************************
   // register map, byte addresses
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h14;
   localparam logic [7:0] ADDR_BUF  = 8'h18;
   localparam logic [7:0] ADDR_STAT = 8'h1C;
   localparam logic [7:0] ADDR_DIR  = 8'h20;
   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int         DIR_DOUT  = 0;
   localparam int         DIR_SCLK  = 1;
   localparam int         PIN_SCLK  = 0;
   localparam int         PIN_DIN   = 1;
   localparam int         PIN_SSEL  = 2;
   localparam int         HTRANS_ACT = 1;
   localparam logic [3:0] MODE_RST  = 4'h0;
   localparam logic [2:0] DIR_RST   = 3'h7;
   localparam logic [2:0] PIN_RST   = 3'h4;
   localparam logic [7:0] BYTE_RST  = 8'h00;
   localparam logic       HRESP_OKAY = 1'b0;
   // ****************************************
   // mode codes
   // ****************************************
   localparam logic [3:0] MODE_M4   = 4'h0;
   localparam logic [3:0] MODE_M16  = 4'h1;
   localparam logic [3:0] MODE_M64  = 4'h2;
   localparam logic [3:0] MODE_MT2  = 4'h3;
   localparam logic [3:0] MODE_SSS  = 4'h4;
   localparam logic [3:0] MODE_SNS  = 4'h5;
   // ****************************************
   // timing: half serial clock period minus one
   // ****************************************
   localparam logic [5:0] HALF4_M1  = 6'h01;
   localparam logic [5:0] HALF16_M1 = 6'h07;
   localparam logic [5:0] HALF64_M1 = 6'h1F;
   localparam logic [4:0] EDGE_END  = 5'h10;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   typedef enum logic [1:0] {MST_IDLE, MST_SHIFT} ssport_mst_t;
endpackage : ssport_pkg

// ### bench/ssport_peer.sv
`timescale 1ns/100ps
module ssport_peer (
   // clock and data from the port
   input  wire logic sclk_in,
   input  wire logic mosi,
   // toward the port
   output logic      miso,
   output logic      sclk_out
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic       act;
   logic       mo;
   initial
   begin
      tx_q = 8'h00;
      rx_q = 8'h00;
      act = 1'b0;
      mo = 1'b0;
      sclk_out = 1'b0;
   end
   assign miso = act ? mo : tx_q[7];
   // ****************************************
   // slave role: sample on rise, change on fall
   // ****************************************
   always @(posedge sclk_in) if (!act) rx_q <= {rx_q[6:0], mosi};
   always @(negedge sclk_in) if (!act) tx_q <= {tx_q[6:0], 1'b0};
   task load(input logic [7:0] b);
      // step off the clock edge
      #1;
      act = 1'b0;
      tx_q = b;
   endtask : load
   // ****************************************
   // master role: clock stands low between frames
   // ****************************************
   task xfer(input logic [7:0] b);
      #1;
      act = 1'b1;
      for (int i = 0; i < 8; i++)
      begin
         mo = b[7-i];
         #40;
         sclk_out = 1'b1;
         rx_q = {rx_q[6:0], mosi};
         #40;
         sclk_out = 1'b0;
      end
      #40;
      // released line shows the inverse, not a held bit
      mo = ~mo;
   endtask : xfer
endmodule : ssport_peer

// ### bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        tick = 1'b0;
   logic        ss_n = 1'b1;
   logic        sclk_o, sclk_oe_n, dout, dout_oe_n, pins, sspin, irq;
   logic        peer_sclk, peer_miso;
   logic [31:0] rdat;
   logic [7:0]  m;
   logic [7:0]  s;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          pulses = 0;
   always #2 clk = ~clk;
   ssport_top u_ssport_top (.clk(clk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_two_tick(tick), .sclk_i(sclk_oe_n ? peer_sclk : sclk_o),
      .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .data_in_i(peer_miso), .data_out_o(dout),
      .data_out_oe_n(dout_oe_n), .slave_sel_n_i(ss_n), .port_pins_sel(pins), .ss_pin_sel(sspin),
      .port_interrupt_flag(irq));
   ssport_peer u_ssport_peer (.sclk_in(sclk_o), .mosi(dout_oe_n ? ~dout : dout), .miso(peer_miso),
      .sclk_out(peer_sclk));
   always @(posedge sclk_o) pulses++;
   // ****************************************
   // timer pulses and hang limit
   // ****************************************
   always @(posedge clk)
   begin
      cyc++;
      tick <= (cyc % 4 == 0);
      if (cyc == 20000)
      begin
         num_errors++;
         results();
      end
   end
   task results;
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // one single transfer; read data lands in rdat
   task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask : bus
   task wfull;
      rdat = 32'h0;
      for (int i = 0; i < 400 && rdat[0] !== 1'b1; i++) bus(ssport_pkg::ADDR_STAT, 1'b0, 8'h00);
   endtask : wfull
   task rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk(n, rdat, {24'h000000, e});
   endtask : rdchk
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rdchk("ctrl_rst", ssport_pkg::ADDR_CTRL, 8'h00);
      rdchk("dir_rst", ssport_pkg::ADDR_DIR, 8'h07);
      rdchk("stat_rst", ssport_pkg::ADDR_STAT, 8'h00);
      chk("hresp", hresp, 1'b0);
      bus(ssport_pkg::ADDR_DIR, 1'b1, 8'h04);
      for (int i = 0; i < 4; i++)
      begin
         m = i[7:0];
         s = {i[0], 7'h40};
         bus(ssport_pkg::ADDR_CTRL, 1'b1, m);
         bus(ssport_pkg::ADDR_STAT, 1'b1, s);
         bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h20 | m);
         repeat (2) @(posedge clk);
         chk("pins_master", pins, 1'b1);
         chk("sclk_drive", sclk_oe_n, 1'b0);
         u_ssport_peer.load(8'h3C + m);
         pulses = 0;
         bus(ssport_pkg::ADDR_BUF, 1'b1, 8'hA5 + m);
         bus(ssport_pkg::ADDR_BUF, 1'b1, 8'hFF);
         wfull();
         chk("irq", irq, 1'b1);
         rdchk("rx_byte", ssport_pkg::ADDR_BUF, 8'h3C + m);
         rdchk("stat_after", ssport_pkg::ADDR_STAT, s | 8'h02);
         rdchk("ctrl_coll", ssport_pkg::ADDR_CTRL, 8'hA0 | m);
         chk("peer_rx", u_ssport_peer.rx_q, 8'hA5 + m);
         chk("pulses", pulses, 8);
         bus(ssport_pkg::ADDR_STAT, 1'b1, s);
         bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h20 | m);
         rdchk("ctrl_clr", ssport_pkg::ADDR_CTRL, 8'h20 | m);
      end
      bus(ssport_pkg::ADDR_DIR, 1'b1, 8'h05);
      repeat (2) @(posedge clk);
      chk("dout_override", dout_oe_n, 1'b1);
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h26);
      bus(ssport_pkg::ADDR_CTRL, 1'b0, 8'h00);
      chk("pins_i2c_code", pins, 1'b0);
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h30);
      repeat (4) @(posedge clk);
      chk("sclk_idle_hi", sclk_o, 1'b1);
      // slave with select; edge bit set needs select control
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h04);
      bus(ssport_pkg::ADDR_STAT, 1'b1, 8'h40);
      bus(ssport_pkg::ADDR_DIR, 1'b1, 8'h06);
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h24);
      repeat (2) @(posedge clk);
      chk("ss_pin_sel", sspin, 1'b1);
      ss_n <= 1'b0;
      bus(ssport_pkg::ADDR_BUF, 1'b1, 8'h96);
      u_ssport_peer.xfer(8'h5A);
      chk("slave_tx", u_ssport_peer.rx_q, 8'h96);
      wfull();
      rdchk("no_ovf", ssport_pkg::ADDR_CTRL, 8'h24);
      u_ssport_peer.xfer(8'hC3);
      repeat (20) @(posedge clk);
      rdchk("ovf_set", ssport_pkg::ADDR_CTRL, 8'h64);
      rdchk("ovf_keep", ssport_pkg::ADDR_BUF, 8'h5A);
      rdchk("ovf_stays", ssport_pkg::ADDR_CTRL, 8'h64);
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h24);
      rdchk("ovf_clr", ssport_pkg::ADDR_CTRL, 8'h24);
      u_ssport_peer.xfer(8'h81);
      wfull();
      rdchk("slave_rd", ssport_pkg::ADDR_BUF, 8'h81);
      rdchk("no_ovf2", ssport_pkg::ADDR_CTRL, 8'h24);
      ss_n <= 1'b1;
      bus(ssport_pkg::ADDR_DIR, 1'b1, 8'h02);
      rdchk("dir_ss_hi", ssport_pkg::ADDR_DIR, 8'h03);
      chk("dout_float", dout_oe_n, 1'b1);
      ss_n <= 1'b0;
      // select passes the pin synchroniser first
      repeat (4) @(posedge clk);
      rdchk("dir_ss_lo", ssport_pkg::ADDR_DIR, 8'h02);
      bus(ssport_pkg::ADDR_STAT, 1'b1, 8'h00);
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h25);
      bus(ssport_pkg::ADDR_CTRL, 1'b0, 8'h00);
      chk("ss_pin_free", sspin, 1'b0);
      bus(ssport_pkg::ADDR_CTRL, 1'b1, 8'h05);
      bus(ssport_pkg::ADDR_CTRL, 1'b0, 8'h00);
      chk("pins_off", pins, 1'b0);
      results();
   end
endmodule : tb_top
